//--- sdc_host_model.sv
// host controller model driving the three-wire programming link
`timescale 1ns/100ps
module sdc_host_model (
	output logic link_clk_o,
	output logic serial_data_o,
	output logic load_strobe_o
);
	// link idles with clock parked low and strobe low
	initial begin
		link_clk_o = 1'b0;
		serial_data_o = 1'b0;
		load_strobe_o = 1'b0;
	end

	// one frame at a 125 ns bit time; clock stands still between frames
	task automatic send(input logic [17:0] w);
		#7;
		for (int i = 17; i >= 0; i--) begin
			serial_data_o = w[i];
			#62.5 link_clk_o = 1'b1;
			#62.5 link_clk_o = 1'b0;
		end
		// released data line flips so a stale bit can never pass for good data
		serial_data_o = ~w[0];
		#50 load_strobe_o = 1'b1;
		// clock kept quiet well past the strobe rise to avoid a torn word
		#150 load_strobe_o = 1'b0;
		#150;
	endtask : send
endmodule : sdc_host_model

//--- sdc_pkg.sv
// constants, word layouts and helper functions for the synthesizer divider control core
package sdc_pkg;
	localparam int SHIFT_W = 18;
	localparam int ADDR_POS = 0;
	localparam logic ADDR_REF = 1'b1;
	// word fields sit just above the address bit
	localparam int REF_LSB = 1;
	localparam int REF_MSB = 14;
	localparam int MAIN_LSB = 1;
	localparam int MAIN_MSB = 17;
	// power-up contents: dividers minimal and legal, pump floating, loop asleep
	localparam logic [13:0] REF_RST = 14'h0402;
	localparam logic [16:0] MAIN_RST = 17'h00183;
	localparam logic [SHIFT_W-1:0] SHIFT_RST = 18'h00000;
	localparam logic [1:0] CTL_NORMAL = 2'h0;
	localparam logic [1:0] CTL_SYNC_PD = 2'h1;
	localparam logic [1:0] CTL_CLEAR = 2'h2;
	localparam logic [1:0] CTL_ASYNC_PD = 2'h3;
	// positions in the pin synchroniser vector
	localparam int PIN_CE = 0;
	localparam int PIN_LE = 1;
	localparam int PIN_REF = 2;
	localparam int PIN_PRE = 3;
	localparam logic [3:0] PINS_RST = 4'h0;

	typedef struct packed {
		logic test;
		logic reserved_bit;
		logic detector_polarity;
		logic pump_float;
		logic [9:0] ref_divide_value;
	} sdc_ref_word_t;

	typedef struct packed {
		logic [9:0] main_count_value;
		logic [4:0] swallow_count_value;
		logic [1:0] control_field;
	} sdc_main_word_t;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_WAIT = 2'b01,
		PWR_SLEEP = 2'b10
	} sdc_pwr_t;

	// true on the input edge that closes a divider period
	function automatic logic sdc_wrap(input logic [9:0] cnt, input logic [9:0] lim, input logic tick,
		input logic hold);
		return !hold && tick && (cnt >= lim - 10'h001);
	endfunction : sdc_wrap

	// next value of a divider count that runs 0..lim-1 and sits at zero while held
	function automatic logic [9:0] sdc_step(input logic [9:0] cnt, input logic [9:0] lim, input logic tick,
		input logic hold);
		logic [9:0] nxt;
		nxt = cnt;
		if (hold || sdc_wrap(cnt, lim, tick, hold)) begin
			nxt = 10'h000;
		end else if (tick) begin
			nxt = cnt + 10'h001;
		end
		return nxt;
	endfunction : sdc_step
endpackage : sdc_pkg

//--- sdc_top.sv
// serial-programmed divider, power and charge pump control core of the synthesizer
`timescale 1ns/100ps
module sdc_top
	import sdc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	input wire logic serial_data_i,
	input wire logic load_strobe_i,
	input wire logic chip_enable_i,
	input wire logic ref_in_i,
	input wire logic presc_in_i,
	output logic mod_sel_o,
	output logic pump_output_o,
	output logic pump_output_oe_o,
	output logic ref_div_o,
	output logic main_div_o,
	output logic sleep_o
);
	logic rst_meta_q;
	logic rst_n_q;
	logic [3:0] pins_s1_q;
	logic [3:0] pins_s2_q;
	logic [3:0] pins_prev_q;
	logic [SHIFT_W-1:0] shift_q;
	logic [SHIFT_W-1:0] shift_d;
	sdc_ref_word_t ref_q;
	sdc_ref_word_t ref_d;
	sdc_main_word_t main_q;
	sdc_main_word_t main_d;
	sdc_pwr_t pwr_q;
	sdc_pwr_t pwr_d;
	logic [9:0] r_cnt_q;
	logic [9:0] r_cnt_d;
	logic [9:0] b_cnt_q;
	logic [9:0] b_cnt_d;
	logic ref_div_q;
	logic ref_div_d;
	logic main_div_q;
	logic main_div_d;
	logic mod_sel_q;
	logic mod_sel_d;
	logic up_q;
	logic up_d;
	logic dn_q;
	logic dn_d;
	logic pump_q;
	logic pump_d;
	logic pump_oe_q;
	logic pump_oe_d;
	logic sleep_q;
	logic load_pulse;
	logic ce_s;
	logic ref_tick;
	logic pre_tick;
	logic async_pd;
	logic hold_w;

	// reset release is synchronised; assertion stays asynchronous
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// link side: shifter runs on the host clock so it keeps loading in every power mode
	always_comb begin
		shift_d = {shift_q[SHIFT_W-2:0], serial_data_i};
	end

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_q <= SHIFT_RST;
		end else begin
			shift_q <= shift_d;
		end
	end

	// pins pass two flops; the third stage only feeds the edge detectors
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pins_s1_q <= PINS_RST;
			pins_s2_q <= PINS_RST;
			pins_prev_q <= PINS_RST;
		end else begin
			pins_s1_q <= {presc_in_i, ref_in_i, load_strobe_i, chip_enable_i};
			pins_s2_q <= pins_s1_q;
			pins_prev_q <= pins_s2_q;
		end
	end

	// the shifter is quiet while the strobe rises, so its word is stable when sampled here
	assign load_pulse = pins_s2_q[PIN_LE] && !pins_prev_q[PIN_LE];
	assign ce_s = pins_s2_q[PIN_CE];
	assign ref_tick = pins_s2_q[PIN_REF] && !pins_prev_q[PIN_REF];
	assign pre_tick = pins_s2_q[PIN_PRE] && !pins_prev_q[PIN_PRE];

	// word latches, address bit picks the target
	always_comb begin
		ref_d = ref_q;
		main_d = main_q;
		if (load_pulse) begin
			if (shift_q[ADDR_POS] == ADDR_REF) begin
				ref_d = sdc_ref_word_t'(shift_q[REF_MSB:REF_LSB]);
			end else begin
				main_d = sdc_main_word_t'(shift_q[MAIN_MSB:MAIN_LSB]);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ref_q <= sdc_ref_word_t'(REF_RST);
			main_q <= sdc_main_word_t'(MAIN_RST);
		end else begin
			ref_q <= ref_d;
			main_q <= main_d;
		end
	end

	// power mode: enable pin low or code 11 sleeps at once, code 01 waits for a quiet pump
	assign async_pd = !ce_s || (main_q.control_field == CTL_ASYNC_PD);

	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			PWR_RUN: begin
				if (async_pd) begin
					pwr_d = PWR_SLEEP;
				end else if (main_q.control_field == CTL_SYNC_PD) begin
					pwr_d = PWR_WAIT;
				end
			end
			PWR_WAIT: begin
				if (async_pd) begin
					pwr_d = PWR_SLEEP;
				end else if (main_q.control_field != CTL_SYNC_PD) begin
					pwr_d = PWR_RUN;
				end else if (!(up_q || dn_q)) begin
					pwr_d = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				if (!async_pd && main_q.control_field != CTL_SYNC_PD) begin
					pwr_d = PWR_RUN;
				end
			end
			default: begin
				pwr_d = PWR_SLEEP;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pwr_q <= PWR_SLEEP;
			sleep_q <= 1'b1;
		end else begin
			pwr_q <= pwr_d;
			sleep_q <= (pwr_d == PWR_SLEEP);
		end
	end

	// dividers sit at zero while asleep or cleared, so both restart together
	assign hold_w = (pwr_q == PWR_SLEEP) || (main_q.control_field == CTL_CLEAR);

	always_comb begin
		r_cnt_d = sdc_step(r_cnt_q, ref_q.ref_divide_value, ref_tick, hold_w);
		ref_div_d = sdc_wrap(r_cnt_q, ref_q.ref_divide_value, ref_tick, hold_w);
		// one count per prescaler cycle; the first swallow-count cycles run at 33
		b_cnt_d = sdc_step(b_cnt_q, main_q.main_count_value, pre_tick, hold_w);
		main_div_d = sdc_wrap(b_cnt_q, main_q.main_count_value, pre_tick, hold_w);
		mod_sel_d = (b_cnt_d < {5'h00, main_q.swallow_count_value});
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			r_cnt_q <= 10'h000;
			b_cnt_q <= 10'h000;
			ref_div_q <= 1'b0;
			main_div_q <= 1'b0;
			mod_sel_q <= 1'b0;
		end else begin
			r_cnt_q <= r_cnt_d;
			b_cnt_q <= b_cnt_d;
			ref_div_q <= ref_div_d;
			main_div_q <= main_div_d;
			mod_sel_q <= mod_sel_d;
		end
	end

	// phase detector and pump pin; a pulse in progress is up or down still set
	always_comb begin
		up_d = (up_q || ref_div_q) && !hold_w;
		dn_d = (dn_q || main_div_q) && !hold_w;
		if (up_d && dn_d) begin
			up_d = 1'b0;
			dn_d = 1'b0;
		end
		pump_d = 1'b0;
		pump_oe_d = 1'b0;
		if (pwr_q == PWR_SLEEP) begin
			pump_oe_d = 1'b0;
		end else if (ref_q.test) begin
			pump_oe_d = 1'b1;
			pump_d = ref_q.detector_polarity ? main_div_q : ref_div_q;
		end else if (!ref_q.pump_float) begin
			pump_oe_d = up_q ^ dn_q;
			pump_d = ref_q.detector_polarity ? up_q : dn_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
			pump_q <= 1'b0;
			pump_oe_q <= 1'b0;
		end else begin
			up_q <= up_d;
			dn_q <= dn_d;
			pump_q <= pump_d;
			pump_oe_q <= pump_oe_d;
		end
	end

	assign mod_sel_o = mod_sel_q;
	assign pump_output_o = pump_q;
	assign pump_output_oe_o = pump_oe_q;
	assign ref_div_o = ref_div_q;
	assign main_div_o = main_div_q;
	assign sleep_o = sleep_q;

	// checks
	sequence s_busy_wait;
		(pwr_q == PWR_WAIT) && (up_q || dn_q);
	endsequence

	sequence s_quiet_wait;
		(pwr_q == PWR_WAIT) && !up_q && !dn_q && ce_s && (main_q.control_field == CTL_SYNC_PD);
	endsequence

	property p_shift_in;
		@(posedge link_clk_i) disable iff (!resetn_i)
		1'b1 |=> (shift_q[0] == $past(serial_data_i)) && (shift_q[17:1] == $past(shift_q[16:0]));
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("shift register did not take serial bit");

	property p_load_main;
		@(posedge clk_i) disable iff (!rst_n_q)
		load_pulse && (shift_q[ADDR_POS] != ADDR_REF) |=> (main_q == $past(shift_q[17:1])) && $stable(ref_q);
	endproperty
	a_load_main: assert property (p_load_main) else $error("main word not loaded");

	property p_load_ref;
		@(posedge clk_i) disable iff (!rst_n_q)
		load_pulse && (shift_q[ADDR_POS] == ADDR_REF) |=> (ref_q == $past(shift_q[14:1])) && $stable(main_q);
	endproperty
	a_load_ref: assert property (p_load_ref) else $error("reference word not loaded");

	property p_async_pd;
		@(posedge clk_i) disable iff (!rst_n_q)
		async_pd |=> (pwr_q == PWR_SLEEP) && sleep_o;
	endproperty
	a_async_pd: assert property (p_async_pd) else $error("asynchronous power-down late");

	property p_sync_wait;
		@(posedge clk_i) disable iff (!rst_n_q)
		s_busy_wait and !async_pd |=> (pwr_q != PWR_SLEEP);
	endproperty
	a_sync_wait: assert property (p_sync_wait) else $error("slept during pump pulse");

	property p_sync_done;
		@(posedge clk_i) disable iff (!rst_n_q)
		s_quiet_wait |=> (pwr_q == PWR_SLEEP);
	endproperty
	a_sync_done: assert property (p_sync_done) else $error("synchronous power-down not taken");

	property p_hold;
		@(posedge clk_i) disable iff (!rst_n_q)
		hold_w |=> (r_cnt_q == 10'h000) && (b_cnt_q == 10'h000) && !main_div_o && !ref_div_o;
	endproperty
	a_hold: assert property (p_hold) else $error("dividers not held at zero");

	property p_mod_sel;
		@(posedge clk_i) disable iff (!rst_n_q)
		$stable(main_q) |-> (mod_sel_o == (b_cnt_q < {5'h00, main_q.swallow_count_value}));
	endproperty
	a_mod_sel: assert property (p_mod_sel) else $error("wrong prescaler modulus request");

	property p_main_end;
		@(posedge clk_i) disable iff (!rst_n_q)
		pre_tick && !hold_w && (b_cnt_q == main_q.main_count_value - 10'h001) |=> main_div_o && (b_cnt_q == 10'h000);
	endproperty
	a_main_end: assert property (p_main_end) else $error("main period end missed");

	property p_float;
		@(posedge clk_i) disable iff (!rst_n_q)
		ref_q.pump_float && !ref_q.test |=> !pump_output_oe_o;
	endproperty
	a_float: assert property (p_float) else $error("pump driven while floating");

	property p_test_route;
		@(posedge clk_i) disable iff (!rst_n_q)
		ref_q.test && (pwr_q != PWR_SLEEP) |=>
			pump_output_oe_o && (pump_output_o == ($past(ref_q.detector_polarity) ? $past(main_div_q) : $past(ref_div_q)));
	endproperty
	a_test_route: assert property (p_test_route) else $error("test routing wrong");

	property p_polarity;
		@(posedge clk_i) disable iff (!rst_n_q)
		!ref_q.test && !ref_q.pump_float && (pwr_q != PWR_SLEEP) && up_q && !dn_q |=>
			pump_output_oe_o && (pump_output_o == $past(ref_q.detector_polarity));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pump direction wrong for polarity");
endmodule : sdc_top

//--- synth_divider_control_bench.sv
// self-checking bench for the divider control core
`timescale 1ns/100ps
module synth_divider_control_bench;
	import sdc_pkg::*;
	logic clk_i = 1'b0, resetn_i = 1'b1, chip_enable_i = 1'b0, ref_in_i = 1'b0, presc_in_i = 1'b0;
	logic link_clk, sdata, strobe, mod_sel_o, pump_output_o, pump_output_oe_o, ref_div_o, main_div_o, sleep_o;
	logic pol, saw_oe, ref_q, main_q;
	logic [9:0] r, b;
	logic [4:0] a;
	int failures = 0, n_tests = 0, seed = 30821, cyc = 0, n_ref, n_main, rf, mode_chk = 0;
	int q_ref[$], q_main[$];

	sdc_host_model host (.link_clk_o(link_clk), .serial_data_o(sdata), .load_strobe_o(strobe));
	sdc_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk), .serial_data_i(sdata),
		.load_strobe_i(strobe), .chip_enable_i(chip_enable_i), .ref_in_i(ref_in_i), .presc_in_i(presc_in_i),
		.mod_sel_o(mod_sel_o), .pump_output_o(pump_output_o), .pump_output_oe_o(pump_output_oe_o),
		.ref_div_o(ref_div_o), .main_div_o(main_div_o), .sleep_o(sleep_o));

	always #12.5 clk_i = ~clk_i;

	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic summarize;
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// reserved bit always zero, top three bits unused
	function automatic logic [17:0] ref_w(input logic t, input logic p, input logic f);
		return {3'h0, t, 1'b0, p, f, r, ADDR_REF};
	endfunction : ref_w

	function automatic logic [17:0] main_w(input logic [1:0] c);
		return {b, a, c, ~ADDR_REF};
	endfunction : main_w

	// slow reference and prescaler edges; live runs note each expected period end
	task automatic run(input int n, input logic live);
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (live) begin
				rf += mod_sel_o ? 33 : 32;
				n_ref++;
				n_main++;
				if (n_ref % r == 0) q_ref.push_back(n_ref);
				if (n_main % b == 0) q_main.push_back(n_main / b * (32 * b + a));
			end
			ref_in_i = 1'b1;
			presc_in_i = 1'b1;
			repeat (4) @(posedge clk_i);
			#1;
			ref_in_i = 1'b0;
			presc_in_i = 1'b0;
			repeat (3 + $unsigned($random(seed)) % 3) @(posedge clk_i);
		end
	endtask : run

	task automatic wait_sleep(input logic lvl, input int lim);
		for (int k = 0; k < lim && sleep_o !== lvl; k++) begin
			@(posedge clk_i);
			#1;
		end
		check(sleep_o === lvl, "power state");
	endtask : wait_sleep

	// output watcher on the falling edge, where registered outputs have settled
	always @(negedge clk_i) begin
		if (mode_chk == 1) check(pump_output_oe_o === 1'b1 && pump_output_o === (pol ? main_q : ref_q), "test route");
		if (mode_chk == 2) check(pump_output_oe_o === 1'b0, "pump float");
		if (mode_chk == 3 && pump_output_oe_o === 1'b1 && !saw_oe) check(pump_output_o === (pol ~^ (r < b)), "polarity");
		if (pump_output_oe_o === 1'b1) saw_oe = 1'b1;
		ref_q = ref_div_o;
		main_q = main_div_o;
		if (ref_div_o === 1'b1) begin
			if (q_ref.size() == 0) check(1'b0, "stray reference pulse");
			else check(q_ref.pop_front() === n_ref, "reference period");
		end
		if (main_div_o === 1'b1) begin
			if (q_main.size() == 0) check(1'b0, "stray main pulse");
			else check(q_main.pop_front() === rf, "main ratio");
		end
	end

	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end

	// main sequence: four pump configurations, then the power modes
	initial begin
		// a real falling edge on reset, so the link shifter is cleared before its first bit
		#2;
		resetn_i = 1'b0;
		repeat (6) @(posedge clk_i);
		check(sleep_o === 1'b1 && pump_output_oe_o === 1'b0, "reset state");
		#1;
		resetn_i = 1'b1;
		chip_enable_i = 1'b1;
		for (int c = 0; c < 4; c++) begin
			mode_chk = 0;
			r = 10'h002 + $unsigned($random(seed)) % 8;
			b = 10'h003 + $unsigned($random(seed)) % 6;
			if (r == b) r++;
			a = $unsigned($random(seed)) % (b + 1);
			pol = (c == 3) || (c == 0 && $random(seed) % 2 != 0);
			host.send(main_w(CTL_CLEAR));
			check(sleep_o === 1'b0, "clear keeps power");
			run(4, 1'b0);
			host.send(ref_w(c > 1, pol, c > 0));
			host.send(main_w(CTL_NORMAL));
			n_ref = 0;
			n_main = 0;
			rf = 0;
			saw_oe = 1'b0;
			mode_chk = (c > 1) ? 1 : 3 - c;
			run(20, 1'b1);
			repeat (8) @(posedge clk_i);
			check(q_ref.size() + q_main.size() === 0, "missing period end");
			if (c == 0) check(saw_oe === 1'b1, "pump active");
		end
		mode_chk = 0;
		host.send(main_w(CTL_ASYNC_PD));
		check(sleep_o === 1'b1, "async sleep");
		run(6, 1'b0);
		host.send(main_w(CTL_NORMAL));
		check(sleep_o === 1'b0, "load while asleep");
		// leave one detector pulse pending, so the synchronous sleep has to wait for its end
		n_ref = 0;
		n_main = 0;
		rf = 0;
		run((r < b) ? r : b, 1'b1);
		host.send(main_w(CTL_SYNC_PD));
		check(sleep_o === 1'b0, "slept during pump pulse");
		run((r < b) ? b - r : r - b, 1'b1);
		wait_sleep(1'b1, 40);
		host.send(main_w(CTL_NORMAL));
		@(posedge clk_i);
		#1;
		chip_enable_i = 1'b0;
		wait_sleep(1'b1, 8);
		#1;
		chip_enable_i = 1'b1;
		wait_sleep(1'b0, 8);
		n_ref = 0;
		n_main = 0;
		rf = 0;
		run(12, 1'b1);
		repeat (8) @(posedge clk_i);
		check(q_ref.size() + q_main.size() === 0, "restart from zero");
		summarize();
	end
endmodule : synth_divider_control_bench
